// file: logic/tpm_monitor.sv
// TLP performance monitor with register slave
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module tpm_monitor #(
    parameter int SEC_CYCLES = tpm_pkg::SECOND_CYCLES,
    parameter int CNT_W = 32
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [11:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire tpm_pkg::tpm_tlp_t tx_tlp_in,
    input wire tpm_pkg::tpm_tlp_t rx_tlp_in,
    output logic counting_out
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic cnt_hit(input int idx, input tpm_pkg::tpm_tlp_t tx,
                                     input tpm_pkg::tpm_tlp_t rx);
        case (idx)
            tpm_pkg::IDX_TX_MRD: cnt_hit = tx.valid & tx.mem_rd;
            tpm_pkg::IDX_TX_MWR: cnt_hit = tx.valid & tx.mem_wr;
            tpm_pkg::IDX_TX_MSG: cnt_hit = tx.valid & tx.msg;
            tpm_pkg::IDX_TX_CFGWR: cnt_hit = tx.valid & tx.cfg_wr;
            tpm_pkg::IDX_TX_CFGRD: cnt_hit = tx.valid & tx.cfg_rd;
            tpm_pkg::IDX_RX_MRD: cnt_hit = rx.valid & rx.mem_rd;
            tpm_pkg::IDX_RX_MWR: cnt_hit = rx.valid & rx.mem_wr;
            tpm_pkg::IDX_RX_MSG: cnt_hit = rx.valid & rx.msg;
            tpm_pkg::IDX_RX_CFGWR: cnt_hit = rx.valid & rx.cfg_wr;
            tpm_pkg::IDX_RX_CFGRD: cnt_hit = rx.valid & rx.cfg_rd;
            default: cnt_hit = 1'b0;
        endcase
    endfunction

    localparam int NKB = 4;
    localparam int FIRST_KB = tpm_pkg::IDX_TX_MEM_KB;

    // ****************************************
    // Bus slave: one wait cycle per access
    // ****************************************
    logic [31:0] ctrl_reg;
    logic [CNT_W-1:0] cnt_reg [tpm_pkg::NUM_CNT];
    logic [9:0] rem_reg [NKB];
    logic ack_reg;
    logic req;
    logic wr_take;
    logic ctrl_sel;
    logic cnt_sel;
    logic [3:0] cnt_idx;
    logic [11:0] rel_addr;
    logic clear_all;
    logic [31:0] wmask;

    // Request is seen only while no answer is pending, so one access gives one answer
    assign req = (read_in | write_in) & ~ack_reg;
    assign wr_take = write_in & ack_reg;
    assign wmask = be_mask(byteenable_in);

    always_comb begin
        rel_addr = address_in - tpm_pkg::BASE_ADDR;
        ctrl_sel = 1'b0;
        cnt_sel = 1'b0;
        cnt_idx = 4'h0;
        if (address_in < tpm_pkg::BASE_ADDR) begin
            ctrl_sel = 1'b0;
        end else if (rel_addr[1:0] != 2'h0) begin
            ctrl_sel = 1'b0;
        end else if (rel_addr == tpm_pkg::OFF_CTRL) begin
            ctrl_sel = 1'b1;
        end else if (rel_addr >= tpm_pkg::OFF_CNT_FIRST && rel_addr <= tpm_pkg::OFF_CNT_LAST) begin
            cnt_sel = 1'b1;
            cnt_idx = 4'(rel_addr[5:2] - 4'h1);
        end
    end

    // ****************************************
    // Handshake and read data
    // ****************************************

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Own flop so the bus never sees a gated level; always the inverse of ack
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            waitrequest_out <= 1'b1;
        end else begin
            waitrequest_out <= ~req;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            readdata_out <= tpm_pkg::UNMAPPED_DATA;
        end else if (read_in & ~ack_reg) begin
            if (ctrl_sel) begin
                readdata_out <= ctrl_reg;
            end else if (cnt_sel) begin
                readdata_out <= 32'(cnt_reg[cnt_idx]);
            end else begin
                readdata_out <= tpm_pkg::UNMAPPED_DATA;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Clear bit is a command: it self-clears and always reads zero
    assign clear_all = wr_take & ctrl_sel & byteenable_in[0] & writedata_in[tpm_pkg::CTRL_CLR_BIT];

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= tpm_pkg::CTRL_RESET;
        end else if (wr_take & ctrl_sel) begin
            ctrl_reg <= (ctrl_reg & ~(wmask & tpm_pkg::CTRL_WMASK)) |
                        (writedata_in & wmask & tpm_pkg::CTRL_WMASK);
        end
    end

    // ****************************************
    // Duration window
    // ****************************************
    tpm_pkg::tpm_state_t state_reg;
    logic [31:0] tick_reg;
    logic [8:0] sec_reg;
    logic enable;
    logic [8:0] duration;
    logic sec_tick;
    logic run;

    assign enable = ctrl_reg[tpm_pkg::CTRL_EN_BIT];
    assign duration = ctrl_reg[tpm_pkg::CTRL_DUR_MSB:tpm_pkg::CTRL_DUR_LSB];
    assign sec_tick = (tick_reg == 32'(SEC_CYCLES - 1));
    assign run = (state_reg == tpm_pkg::TPM_RUN);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= tpm_pkg::TPM_IDLE;
        end else begin
            case (state_reg)
                tpm_pkg::TPM_IDLE: begin
                    if (enable) begin
                        state_reg <= tpm_pkg::TPM_RUN;
                    end
                end
                tpm_pkg::TPM_RUN: begin
                    if (!enable) begin
                        state_reg <= tpm_pkg::TPM_IDLE;
                    end else if (duration != 9'h000 && sec_tick && sec_reg + 9'h001 >= duration) begin
                        state_reg <= tpm_pkg::TPM_DONE;
                    end
                end
                tpm_pkg::TPM_DONE: begin
                    if (!enable) begin
                        state_reg <= tpm_pkg::TPM_IDLE;
                    end
                end
                default: state_reg <= tpm_pkg::TPM_IDLE;
            endcase
        end
    end

    // Seconds count restarts whenever the window is not open.
    // A new duration written mid-window is compared at the next second boundary.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_reg <= 32'h00000000;
            sec_reg <= 9'h000;
        end else if (!run) begin
            tick_reg <= 32'h00000000;
            sec_reg <= 9'h000;
        end else if (sec_tick) begin
            tick_reg <= 32'h00000000;
            if (sec_reg != 9'h1FF) begin
                sec_reg <= sec_reg + 9'h001;
            end
        end else begin
            tick_reg <= tick_reg + 32'h00000001;
        end
    end

    // ****************************************
    // Status output
    // ****************************************

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            counting_out <= 1'b0;
        end else begin
            counting_out <= (state_reg == tpm_pkg::TPM_IDLE) ? enable :
                            (state_reg == tpm_pkg::TPM_RUN) ? enable : 1'b0;
        end
    end

    // ****************************************
    // Clear masks
    // ****************************************

    // Bits that the current bus write clears in counter idx
    function automatic logic [31:0] w1c_bits(input int idx);
        w1c_bits = 32'h00000000;
        if (wr_take && cnt_sel && cnt_idx == 4'(idx)) begin
            w1c_bits = writedata_in & wmask;
        end
    endfunction

    // ****************************************
    // Event counters
    // ****************************************
    // Clear-all beats an event in the same cycle; that event is dropped.
    // Increment wins over a same-cycle write-one-to-clear on any bits;
    // a clearing write lands on the pre-increment value so no event is lost.
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_evt
            always_ff @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    cnt_reg[gi] <= CNT_W'(tpm_pkg::CNT_RESET);
                end else if (clear_all) begin
                    cnt_reg[gi] <= '0;
                end else begin
                    cnt_reg[gi] <= (cnt_reg[gi] & ~CNT_W'(w1c_bits(gi))) +
                                   CNT_W'(run & cnt_hit(gi, tx_tlp_in, rx_tlp_in));
                end
            end
        end

        // ****************************************
        // Payload volume in kilobytes
        // ****************************************
        for (gi = 0; gi < NKB; gi++) begin : g_kb
            logic hit;
            logic [12:0] len;
            logic [13:0] sum;
            always_comb begin
                case (gi)
                    0: hit = tx_tlp_in.valid & tx_tlp_in.mem_wr;
                    1: hit = tx_tlp_in.valid & tx_tlp_in.cpl;
                    2: hit = rx_tlp_in.valid & rx_tlp_in.mem_wr;
                    default: hit = rx_tlp_in.valid & rx_tlp_in.cpl;
                endcase
                len = (gi < 2) ? tx_tlp_in.len_bytes : rx_tlp_in.len_bytes;
                sum = {4'h0, rem_reg[gi]} + ((run & hit) ? {1'b0, len} : 14'h0000);
            end

            always_ff @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    rem_reg[gi] <= 10'h000;
                    cnt_reg[FIRST_KB+gi] <= CNT_W'(tpm_pkg::CNT_RESET);
                end else if (clear_all) begin
                    rem_reg[gi] <= 10'h000;
                    cnt_reg[FIRST_KB+gi] <= '0;
                end else begin
                    rem_reg[gi] <= sum[9:0];
                    cnt_reg[FIRST_KB+gi] <= (cnt_reg[FIRST_KB+gi] & ~CNT_W'(w1c_bits(FIRST_KB + gi))) +
                        CNT_W'(sum[13:10]);
                end
            end
        end
    endgenerate

endmodule

// file: common/tpm_pkg.sv
// Package for the TLP performance monitor: register map, fields, timing
package tpm_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [11:0] BASE_ADDR = 12'h800;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CNT_FIRST = 12'h004;
    localparam logic [11:0] OFF_CNT_LAST = 12'h038;
    localparam int NUM_CNT = 14;

    // Counter index order matches consecutive offsets after the control word
    localparam int IDX_TX_MRD = 0;
    localparam int IDX_TX_MWR = 1;
    localparam int IDX_TX_MSG = 2;
    localparam int IDX_TX_CFGWR = 3;
    localparam int IDX_TX_CFGRD = 4;
    localparam int IDX_RX_MRD = 5;
    localparam int IDX_RX_MWR = 6;
    localparam int IDX_RX_MSG = 7;
    localparam int IDX_RX_CFGWR = 8;
    localparam int IDX_RX_CFGRD = 9;
    localparam int IDX_TX_MEM_KB = 10;
    localparam int IDX_TX_CPL_KB = 11;
    localparam int IDX_RX_MEM_KB = 12;
    localparam int IDX_RX_CPL_KB = 13;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int CTRL_DUR_LSB = 2;
    localparam int CTRL_DUR_MSB = 10;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [31:0] CTRL_WMASK = 32'h000007FD;
    localparam logic [31:0] CNT_RESET = 32'h00000000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

    // ****************************************
    // Timing and volume
    // ****************************************
    localparam int CLK_HZ = 100000000;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
    localparam int KB_BYTES = 1024;
    localparam int LEN_W = 13;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        TPM_IDLE = 3'b001,
        TPM_RUN = 3'b010,
        TPM_DONE = 3'b100
    } tpm_state_t;

    // One observed TLP on a path, valid for a single cycle
    typedef struct packed {
        logic valid;
        logic mem_rd;
        logic mem_wr;
        logic msg;
        logic cfg_wr;
        logic cfg_rd;
        logic cpl;
        logic [12:0] len_bytes;
    } tpm_tlp_t;

endpackage

// file: tb/tpm_monitor_sva.sv
// Concurrent checks on the performance monitor ports
`timescale 1ns/1ns
module tpm_monitor_sva #(
    parameter int SEC_CYCLES = 20,
    parameter int CNT_W = 32
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [11:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    input wire tpm_pkg::tpm_tlp_t tx_tlp_in,
    input wire tpm_pkg::tpm_tlp_t rx_tlp_in,
    input wire logic counting_out
);
    // ****************************************
    // Helper state
    // ****************************************
    logic [8:0] dur_reg;
    logic [31:0] run_reg;
    wire logic take_rd = read_in && waitrequest_out;
    wire logic ctl_wr = write_in && !waitrequest_out && address_in == 12'h800 && byteenable_in == 4'hF;

    // Duration as last written, so window length can be bounded
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dur_reg <= 9'h000;
        end else if (ctl_wr) begin
            dur_reg <= writedata_in[10:2];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            run_reg <= 32'h00000000;
        end else begin
            run_reg <= counting_out ? run_reg + 32'h00000001 : 32'h00000000;
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    chk_wait_one: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("answer not after one wait cycle");
    chk_wait_pulse: assert property (!waitrequest_out |=> waitrequest_out)
        else $error("waitrequest low too long");
    chk_unmapped_zero: assert property (take_rd && (address_in > 12'h838 || address_in < 12'h800
        || address_in[1:0] != 2'b00) |=> readdata_out == 32'h00000000)
        else $error("unmapped read not zero");
    chk_ctrl_fields: assert property (take_rd && address_in == 12'h800
        |=> readdata_out[31:11] == 21'h000000 && !readdata_out[1])
        else $error("control reserved or clear bit reads set");
    chk_reset_clear: assert property ($fell(rst_in) |-> !counting_out && readdata_out == 32'h00000000)
        else $error("state not clear after reset");
    chk_enable_off: assert property (ctl_wr && !writedata_in[0] |-> ##2 !counting_out)
        else $error("counting continues after disable");
    chk_window_len: assert property (counting_out && dur_reg != 9'h000
        |-> run_reg <= dur_reg * SEC_CYCLES + 2)
        else $error("counting window too long");
    chk_read_holds: assert property (!take_rd |=> $stable(readdata_out))
        else $error("read data changed without a read");
endmodule

// file: tb/tpm_tlp_source.sv
// Model of the transmit and receive TLP paths
`timescale 1ns/1ns
module tpm_tlp_source (
    input wire logic mclk_in,
    output tpm_pkg::tpm_tlp_t tx_out,
    output tpm_pkg::tpm_tlp_t rx_out
);
    // ****************************************
    // Pulse driver
    // ****************************************
    initial begin
        tx_out = '0;
        rx_out = '0;
    end

    // One TLP per path every second cycle at most, never a flood of requests
    task automatic send(input logic rx, input logic [5:0] fl, input logic [12:0] len);
        @(posedge mclk_in);
        if (rx) rx_out <= {1'b1, fl, len};
        else tx_out <= {1'b1, fl, len};
        @(posedge mclk_in);
        // Idle fields scrambled so stale values never pass as a TLP
        if (rx) rx_out <= {1'b0, ~rx_out[18:0]};
        else tx_out <= {1'b0, ~tx_out[18:0]};
    endtask
endmodule

// file: tb/tpm_monitor_tb_top.sv
// Self-checking bench for the TLP performance monitor
`timescale 1ns/1ns
module tpm_monitor_tb_top;
    // ****************************************
    // Stimulus and checks
    // ****************************************
    localparam int SEC = 20;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] address_in = 12'h000;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [31:0] writedata_in = 32'h00000000;
    logic [3:0] byteenable_in = 4'hF;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic counting_out;
    tpm_pkg::tpm_tlp_t tx_tlp;
    tpm_pkg::tpm_tlp_t rx_tlp;
    int num_errors = 0;
    int checks = 0;
    logic [31:0] q;
    logic [31:0] ex [14];

    always #5 mclk_in = ~mclk_in;

    tpm_tlp_source src (.mclk_in(mclk_in), .tx_out(tx_tlp), .rx_out(rx_tlp));
    tpm_monitor #(.SEC_CYCLES(SEC)) dut (.mclk_in(mclk_in), .rst_in(rst_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .tx_tlp_in(tx_tlp),
        .rx_tlp_in(rx_tlp), .counting_out(counting_out));

    task automatic conclude();
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low, whatever the latency
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        address_in <= a;
        read_in <= !w;
        write_in <= w;
        writedata_in <= d;
        do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
        q = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(q, e);
    endtask

    task automatic cnt_chk(input logic e);
        @(negedge mclk_in);
        chk({31'h0, counting_out}, {31'h0, e});
    endtask

    task automatic rd_all();
        for (int i = 0; i < 14; i++) rd_chk(12'h804 + 12'(4 * i), ex[i]);
    endtask

    task automatic t_reset();
        foreach (ex[i]) ex[i] = 32'h00000000;
        rd_all();
        rd_chk(12'h800, 32'h00000000);
        rd_chk(12'h7FC, 32'h00000000);
        rd_chk(12'h806, 32'h00000000);
    endtask

    // Memory reads carry a length too: only writes and completions add volume
    task automatic t_counts();
        bus(1'b1, 12'h800, 32'h00000001);
        bus(1'b1, 12'h83C, 32'hFFFFFFFF);
        for (int k = 0; k < 5; k++) begin
            repeat (k + 1) src.send(1'b0, 6'h20 >> k, 13'h0600);
            repeat (k + 2) src.send(1'b1, 6'h20 >> k, 13'h0600);
            ex[k] = 32'(k + 1);
            ex[k + 5] = 32'(k + 2);
        end
        src.send(1'b0, 6'h01, 13'h0600);
        repeat (2) src.send(1'b0, 6'h01, 13'h0200);
        repeat (2) src.send(1'b1, 6'h01, 13'h0600);
        ex[10] = 32'h00000003;
        ex[11] = 32'h00000002;
        ex[12] = 32'h00000004;
        ex[13] = 32'h00000003;
        rd_all();
    endtask

    task automatic t_w1c();
        bus(1'b1, 12'h828, 32'h00000002);
        rd_chk(12'h828, 32'h00000004);
        bus(1'b1, 12'h82C, 32'h00000001);
        rd_chk(12'h82C, 32'h00000002);
        bus(1'b1, 12'h804, 32'hFFFFFFFF);
        rd_chk(12'h804, 32'h00000000);
    endtask

    task automatic t_clear();
        bus(1'b1, 12'h800, 32'h00000003);
        rd_chk(12'h800, 32'h00000001);
        foreach (ex[i]) ex[i] = 32'h00000000;
        rd_all();
        src.send(1'b0, 6'h08, 13'h0000);
        bus(1'b1, 12'h800, 32'h00000001);
        rd_chk(12'h80C, 32'h00000001);
        bus(1'b1, 12'h800, 32'h00000000);
        src.send(1'b0, 6'h08, 13'h0000);
        rd_chk(12'h80C, 32'h00000001);
        cnt_chk(1'b0);
    endtask

    // One-second window, shortened to SEC cycles
    task automatic t_window();
        bus(1'b1, 12'h800, 32'h00000005);
        repeat (2) @(posedge mclk_in);
        src.send(1'b0, 6'h08, 13'h0000);
        rd_chk(12'h80C, 32'h00000002);
        repeat (2 * SEC) @(posedge mclk_in);
        cnt_chk(1'b0);
        src.send(1'b0, 6'h08, 13'h0000);
        rd_chk(12'h80C, 32'h00000002);
        rd_chk(12'h800, 32'h00000005);
        bus(1'b1, 12'h800, 32'h00000000);
        bus(1'b1, 12'h800, 32'hFFFFFFFF);
        rd_chk(12'h800, 32'h000007FD);
        rd_chk(12'h80C, 32'h00000000);
        cnt_chk(1'b1);
    endtask

    initial begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_counts();
        t_w1c();
        t_clear();
        t_window();
        conclude();
    end

    initial begin
        #100000;
        num_errors++;
        conclude();
    end
endmodule

bind tpm_monitor tpm_monitor_sva #(.SEC_CYCLES(SEC_CYCLES), .CNT_W(CNT_W)) u_sva (.mclk_in(mclk_in),
    .rst_in(rst_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .tx_tlp_in(tx_tlp_in), .rx_tlp_in(rx_tlp_in),
    .counting_out(counting_out));
